// >>> gfc_pkg.sv
// Package for the global function control register block.
// Assumes a 32-bit AHB-Lite slave; two registers in the peripheral space.
package gfc_pkg;
    // Register index as printed; byte address is four times the index.
    localparam logic [15:0] GFC_INDEX = 16'h104f;
    localparam logic [17:0] GFC_ADDR = {GFC_INDEX, 2'b00};
    // Privilege status register, a word above the control register.
    localparam logic [17:0] PRIV_ADDR = 18'h0_4140;
    // Field positions inside the control register.
    localparam int WD_LO_POS = 0;
    localparam int MODE_POS = 2;
    localparam int G3_POS = 3;
    localparam int G2_POS = 4;
    localparam int G1_POS = 5;
    localparam int RSVD_POS = 6;
    localparam int STEST_POS = 7;
    // Every defined bit clears at reset.
    localparam logic [7:0] GFC_RESET = 8'h00;
    // Writable mask: all defined bits, reserved bit 6 excluded.
    localparam logic [7:0] GFC_WMASK = 8'hbf;
    // Watchdog rate codes and the default timer taps they select.
    localparam logic [1:0] WD_TAP9 = 2'h0;
    localparam logic [1:0] WD_TAP15 = 2'h1;
    localparam logic [1:0] WD_TAP19 = 2'h2;
    localparam logic [1:0] WD_OFF = 2'h3;
    localparam logic [4:0] TAP9 = 5'h09;
    localparam logic [4:0] TAP15 = 5'h0f;
    localparam logic [4:0] TAP19 = 5'h13;
    // AHB transfer type encoding for a valid transfer.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// >>> gfc_wr_if.sv
// Write carrier between bus front end and register storage.
// Assumes one clock domain; signals are plain combinational strobes.
`timescale 1ns/10ps
interface gfc_wr_if;
    // Write strobe for the control register, one cycle.
    logic wr_en;
    // Byte written by software.
    logic [7:0] wr_data;
    // Current register contents.
    logic [7:0] value;
    modport bus (output wr_en, output wr_data, input value);
    modport regs (input wr_en, input wr_data, output value);
endinterface

// >>> gfc_regs.sv
// Storage of the global function control byte.
// Assumes the bus side only strobes writes that passed the privilege check.
`timescale 1ns/10ps
module gfc_regs
    import gfc_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Register access.
    gfc_wr_if.regs wr
);
    // All state of this module.
    typedef struct packed
    {
        logic [7:0] ctrl;
    } regs_state_t;

    regs_state_t state_reg;
    regs_state_t state_next;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic: bit 6 is never stored, so it always reads zero.
    always_comb
    begin
        state_next = state_reg;
        if (wr.wr_en)
        begin
            state_next.ctrl = wr.wr_data & GFC_WMASK;
        end
    end

    // State register; every bit clears on reset.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg.ctrl <= GFC_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign wr.value = state_reg.ctrl;

    chk_reset_clears_bits: assert property (@(posedge clock)
        $rose(rst_n) |-> state_reg.ctrl == GFC_RESET)
        else $error("control byte not clear after reset");
    chk_reserved_reads_zero: assert property (@(posedge clock)
        disable iff (!rst_n) state_reg.ctrl[RSVD_POS] == 1'b0)
        else $error("reserved bit stored");
endmodule

// >>> gfc_top.sv
// Global function control register with AHB-Lite slave access.
// Assumes one 25 MHz clock and a single master; zero wait states.
// What this block does
// - Defined bits readable, reset zero, privileged write.
// - Bits 1:0 pick watchdog tap 9/15/19/off.
// - Watchdog rate changes only in privilege mode.
// - Bit 2 selects mode A or B.
// - Bits 3,4,5 set groups 3,2,1 level.
// - Bit 6 reserved; always reads zero.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module gfc_top
    import gfc_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // AHB-Lite slave port.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Privilege window closed by system logic after boot, level.
    input wire logic priv_exit,
    // Decoded control outputs.
    output logic [1:0] watchdog_rate_sel,
    output logic watchdog_enable,
    output logic [4:0] watchdog_tap,
    output logic module_mode_choice,
    output logic group_one_irq_level,
    output logic group_two_irq_level,
    output logic group_three_irq_level,
    output logic self_test_control,
    output logic priv_active
);
    // All state of the bus front end.
    typedef struct packed
    {
        logic wr_pend;
        logic [17:0] addr;
        logic priv;
        logic [31:0] rdata;
    } top_state_t;

    top_state_t state_reg;
    top_state_t state_next;

    // Carrier to the storage module.
    gfc_wr_if wr ();

    // Address phase is valid when selected, NONSEQ and bus ready.
    logic take;
    assign take = hsel && hready && (htrans == HTRANS_NONSEQ);

    ////////////////////////////////////////////////////////////////////
    // Bus front end: capture address phase, write in the data phase.
    always_comb
    begin
        state_next = state_reg;
        state_next.wr_pend = 1'b0;
        // Privilege ends once system logic says so and returns only at reset.
        if (priv_exit)
        begin
            state_next.priv = 1'b0;
        end
        if (take)
        begin
            state_next.wr_pend = hwrite;
            state_next.addr = haddr[17:0];
            // Read data is registered so it stands in the data phase.
            if (!hwrite && haddr[17:0] == GFC_ADDR)
            begin
                state_next.rdata = {24'h0, wr.value};
            end
            else if (!hwrite && haddr[17:0] == PRIV_ADDR)
            begin
                state_next.rdata = {31'h0, state_reg.priv};
            end
            else
            begin
                // Unmapped reads return zero with an OKAY response.
                state_next.rdata = 32'h0;
            end
        end
    end

    // A write lands only while privilege mode is open.
    assign wr.wr_en = state_reg.wr_pend && state_reg.priv &&
        (state_reg.addr == GFC_ADDR);
    assign wr.wr_data = hwdata[7:0];

    // Registers; privilege mode is open from reset onward.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg.wr_pend <= 1'b0;
            state_reg.addr <= 18'h0;
            state_reg.priv <= 1'b1;
            state_reg.rdata <= 32'h0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Storage sits in its own module and only ever sees writes that
    // have already passed the privilege check above.
    gfc_regs u_regs (
        .clock(clock),
        .rst_n(rst_n),
        .wr(wr)
    );

    ////////////////////////////////////////////////////////////////////
    // Field decode; the self-test bit is only passed on, software keeps
    // it low, the block does not police it.
    assign watchdog_rate_sel = wr.value[WD_LO_POS+1:WD_LO_POS];
    assign watchdog_enable = (watchdog_rate_sel != WD_OFF);
    always_comb
    begin
        case (watchdog_rate_sel)
            WD_TAP9: watchdog_tap = TAP9;
            WD_TAP15: watchdog_tap = TAP15;
            WD_TAP19: watchdog_tap = TAP19;
            default: watchdog_tap = 5'h00;
        endcase
    end
    assign module_mode_choice = wr.value[MODE_POS];
    assign group_three_irq_level = wr.value[G3_POS];
    assign group_two_irq_level = wr.value[G2_POS];
    assign group_one_irq_level = wr.value[G1_POS];
    assign self_test_control = wr.value[STEST_POS];
    assign priv_active = state_reg.priv;
    assign hrdata = state_reg.rdata;
    // Zero wait states: every transfer is answered in its own data phase,
    // so the slave never stretches the bus and always answers OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_write_cmd;
        take && hwrite && haddr[17:0] == GFC_ADDR;
    endsequence

    chk_priv_write_lands: assert property (@(posedge clock)
        disable iff (!rst_n) (s_write_cmd and priv_active && !priv_exit)
        ##1 1'b1 |=> wr.value == ($past(hwdata[7:0]) & GFC_WMASK))
        else $error("privileged write not stored");
    chk_unpriv_ignored: assert property (@(posedge clock)
        disable iff (!rst_n) (s_write_cmd and !priv_active)
        ##1 1'b1 |=> $stable(wr.value))
        else $error("unprivileged write changed register");
    chk_rate_sticks: assert property (@(posedge clock)
        disable iff (!rst_n) !priv_active |=> $stable(watchdog_rate_sel))
        else $error("watchdog rate changed outside privilege");
    chk_priv_stays_shut: assert property (@(posedge clock)
        disable iff (!rst_n) !priv_active |=> !priv_active)
        else $error("privilege mode reopened");
    chk_tap_decode: assert property (@(posedge clock)
        disable iff (!rst_n) watchdog_rate_sel == WD_TAP15
        |-> watchdog_tap == TAP15 && watchdog_enable)
        else $error("tap decode wrong");
    chk_wd_off: assert property (@(posedge clock)
        disable iff (!rst_n) (watchdog_rate_sel == WD_OFF) == !watchdog_enable)
        else $error("watchdog disable decode wrong");
    chk_mode_bit: assert property (@(posedge clock)
        disable iff (!rst_n) module_mode_choice == hrdata[MODE_POS] ||
        !($past(take) && !$past(hwrite) && $past(haddr[17:0]) == GFC_ADDR)
        || $past(wr.wr_en))
        else $error("mode output differs from read value");
    chk_group_levels: assert property (@(posedge clock)
        disable iff (!rst_n) wr.wr_en |=> group_one_irq_level ==
        $past(hwdata[G1_POS]) && group_three_irq_level ==
        $past(hwdata[G3_POS]))
        else $error("group level fields misplaced");

    // The other two tap codes, so every code of the field is watched.
    chk_tap_nine: assert property (@(posedge clock)
        disable iff (!rst_n) watchdog_rate_sel == WD_TAP9
        |-> watchdog_tap == TAP9 && watchdog_enable)
        else $error("tap nine decode wrong");
    chk_tap_nineteen: assert property (@(posedge clock)
        disable iff (!rst_n) watchdog_rate_sel == WD_TAP19
        |-> watchdog_tap == TAP19 && watchdog_enable)
        else $error("tap nineteen decode wrong");

    // A landed write shows up in the rate, mode and group-two fields one edge later.
    chk_rate_written: assert property (@(posedge clock)
        disable iff (!rst_n) wr.wr_en |=> watchdog_rate_sel ==
        $past(hwdata[WD_LO_POS+1:WD_LO_POS]))
        else $error("watchdog rate field misplaced");
    chk_mode_written: assert property (@(posedge clock)
        disable iff (!rst_n) wr.wr_en |=> module_mode_choice ==
        $past(hwdata[MODE_POS]))
        else $error("mode field misplaced");
    chk_group_two: assert property (@(posedge clock)
        disable iff (!rst_n) wr.wr_en |=> group_two_irq_level ==
        $past(hwdata[G2_POS]))
        else $error("group two level misplaced");

    ////////////////////////////////////////////////////////////////////
    // Read path: the data phase returns what stood at the address phase.
    sequence s_read_ctrl;
        take && !hwrite && haddr[17:0] == GFC_ADDR;
    endsequence
    sequence s_read_priv;
        take && !hwrite && haddr[17:0] == PRIV_ADDR;
    endsequence

    // The snapshot is taken before a write landing on the same edge, so
    // a read never returns half of a write.
    chk_read_ctrl: assert property (@(posedge clock)
        disable iff (!rst_n) s_read_ctrl
        |=> hrdata == {24'h00_0000, $past(wr.value)})
        else $error("control read data wrong");
    chk_read_priv: assert property (@(posedge clock)
        disable iff (!rst_n) s_read_priv
        |=> hrdata == {31'h0000_0000, $past(priv_active)})
        else $error("privilege read data wrong");
endmodule

// >>> testbench.sv
// Self-checking bench for the global function control register block.
// Assumes gfc_pkg and gfc_top are compiled first; one 25 MHz clock.
`timescale 1ns/10ps
module testbench;
    import gfc_pkg::*;
////////////////////////////////////////////////////////////////////////////
    // Clock, reset and privilege window input.
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic priv_exit = 1'b0;
    // AHB-Lite master side signals.
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp;
    wire hready = hreadyout;
    // Decoded control outputs.
    logic [1:0] watchdog_rate_sel;
    logic [4:0] watchdog_tap;
    logic watchdog_enable, module_mode_choice, self_test_control;
    logic group_one_irq_level, group_two_irq_level, group_three_irq_level;
    logic priv_active;
    // Bench state: model register, model privilege, counters.
    logic [7:0] mreg = 8'h00;
    logic mpriv = 1'b1;
    logic [31:0] rd;
    integer fails = 0;
    integer checks = 0;
    integer cyc = 0;
    integer seed = 32'h91b5;
    integer i;
    localparam logic [31:0] A_GFC = {14'h0, GFC_ADDR};
    localparam logic [31:0] A_PRIV = {14'h0, PRIV_ADDR};
    localparam logic [31:0] A_NONE = 32'h0004_4138;

    gfc_top gfc_top_i (.clock(clock), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .priv_exit(priv_exit),
        .watchdog_rate_sel(watchdog_rate_sel),
        .watchdog_enable(watchdog_enable), .watchdog_tap(watchdog_tap),
        .module_mode_choice(module_mode_choice),
        .group_one_irq_level(group_one_irq_level),
        .group_two_irq_level(group_two_irq_level),
        .group_three_irq_level(group_three_irq_level),
        .self_test_control(self_test_control), .priv_active(priv_active));

    // Free-running clock, half period 20 ns.
    always #20 clock = ~clock;
////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under 2000 cycles.
    always @(posedge clock)
    begin
        cyc = cyc + 1;
        if (cyc > 4000)
        begin
            fails = fails + 1;
            close_out();
        end
    end

    // One comparison with case equality so unknowns never match.
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks = checks + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One AHB single transfer; waits on hready in both phases.
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge clock);
        while (hready !== 1'b1)
            @(posedge clock);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clock);
        while (hready !== 1'b1)
            @(posedge clock);
        q = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    // Model of a bus write: only privileged writes to the register land.
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, rd);
        if (mpriv && a == A_GFC)
            mreg = d & GFC_WMASK;
        #1;
    endtask

    // Reads an address and compares with the model's view of it.
    task automatic rd_chk(input logic [31:0] a);
        bus(1'b0, a, 32'h0, rd);
        if (a == A_GFC)
            chk("gfc read", {24'h0, mreg}, rd);
        else if (a == A_PRIV)
            chk("priv read", {31'h0, mpriv}, rd);
        else
            chk("unmapped read", 32'h0, rd);
    endtask

    // Compares every decoded output with the model register.
    task automatic outs_chk();
        logic [4:0] tap;
        tap = (mreg[1:0] == 2'h0) ? 5'h09 : (mreg[1:0] == 2'h1) ? 5'h0f
            : (mreg[1:0] == 2'h2) ? 5'h13 : 5'h00;
        chk("outputs", {18'h0, mpriv, mreg[7], mreg[5], mreg[4], mreg[3],
            mreg[2], tap, mreg[1:0] != 2'h3, mreg[1:0]},
            {18'h0, priv_active, self_test_control, group_one_irq_level,
            group_two_irq_level, group_three_irq_level, module_mode_choice,
            watchdog_tap, watchdog_enable,
            watchdog_rate_sel});
    endtask
////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        outs_chk();
        rd_chk(A_GFC);
        rd_chk(A_PRIV);
        // Every watchdog code, upper fields random, self-test kept clear.
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(A_GFC, {1'b0, 5'($random(seed)), 2'(i)});
            outs_chk();
            rd_chk(A_GFC);
        end
        // Random mode and level settings, reserved bit set at random.
        repeat (12)
        begin
            wr(A_GFC, 8'($random(seed)) & 8'h7f);
            outs_chk();
            rd_chk(A_GFC);
        end
        // Unmapped write must not disturb the register.
        wr(A_NONE, 8'h7f);
        rd_chk(A_NONE);
        rd_chk(A_GFC);
        // Close the privilege window; later writes are ignored.
        @(posedge clock);
        priv_exit <= 1'b1;
        repeat (3) @(posedge clock);
        priv_exit <= 1'b0;
        mpriv = 1'b0;
        #1;
        outs_chk();
        rd_chk(A_PRIV);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(A_GFC, {2'h0, ~mreg[5:2], 2'(i)});
            outs_chk();
            rd_chk(A_GFC);
        end
        // A second reset reopens privilege and clears the register.
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        mreg = GFC_RESET;
        mpriv = 1'b1;
        #1;
        outs_chk();
        wr(A_GFC, 8'h3e);
        outs_chk();
        close_out();
    end
endmodule
